/* File: hdl/tppt_chan.sv */
`timescale 1ns/1ps
module tppt_chan (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic tick,
  input wire logic [8:0] delay,
  input wire logic [6:0] begin_addr,
  input wire logic [6:0] end_addr,
  input wire logic [7:0] loop_count,
  input wire logic mul_sel,
  input wire logic enable,
  input wire logic [7:0] mem_data,
  output logic [6:0] rd_addr,
  output logic [1:0] state,
  output logic busy
);
  typedef enum logic [1:0] {CH_IDLE, CH_DELAY, CH_RUN} tppt_ch_t;
  tppt_ch_t st;
  logic [8:0] dcnt;
  logic [6:0] wcnt;
  logic [11:0] reps_left;
  wire forever_run = loop_count == tppt_pkg::LOOP_FOREVER;
  wire [11:0] scaled = mul_sel ? {4'h0, loop_count} :
    {4'h0, loop_count} * tppt_pkg::REP_SCALE16;
  // once for zero, else count scaled by multiplier select
  wire [11:0] rep_total = (loop_count == tppt_pkg::LOOP_ONCE) ?
    12'h001 : scaled;
  wire dly_done = st == CH_DELAY && dcnt == delay;
  wire [6:0] hold_last = {1'b0, mem_data[tppt_pkg::ENT_WIDTH_MSB:0]}
    + tppt_pkg::WIDTH_EXTRA - 7'h01;
  wire step = st == CH_RUN && tick && wcnt == hold_last;
  wire at_end = rd_addr == end_addr;
  wire again = forever_run || reps_left > 12'h001;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= CH_IDLE;
      dcnt <= 9'h000;
      wcnt <= 7'h00;
      reps_left <= 12'h000;
      rd_addr <= 7'h00;
    end else if (start) begin
      st <= CH_DELAY;
      dcnt <= 9'h000;
    end else if (dly_done) begin
      st <= CH_RUN;
      rd_addr <= begin_addr;
      wcnt <= 7'h00;
      reps_left <= rep_total;
    end else if (st == CH_DELAY && tick) begin
      dcnt <= dcnt + 9'h001;
    end else if (step) begin
      wcnt <= 7'h00;
      if (!at_end) begin
        rd_addr <= rd_addr + 7'h01;
      end else if (again) begin
        rd_addr <= begin_addr;
        if (!forever_run) begin
          reps_left <= reps_left - 12'h001;
        end
      end else begin
        st <= CH_IDLE;
      end
    end else if (st == CH_RUN && tick) begin
      wcnt <= wcnt + 7'h01;
    end
  end

  // drive entry state only on active channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= tppt_pkg::STATE_IDLE;
    end else if (st == CH_RUN && enable) begin
      state <= mem_data[7:tppt_pkg::ENT_STATE_LSB];
    end else begin
      state <= tppt_pkg::STATE_IDLE;
    end
  end

  assign busy = st != CH_IDLE;

  // ticks seen on the current entry, kept apart from the width counter
  logic [6:0] seen_ticks;
  always_ff @(posedge aclk) begin
    if (!aresetn || st != CH_RUN || step) begin
      seen_ticks <= 7'h00;
    end else if (tick) begin
      seen_ticks <= seen_ticks + 7'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mask_gate_a: assert property (!enable |=> state == 2'h0)
    else $error("inactive channel drove a state");
  width_hold_a: assert property (
    step |-> seen_ticks + 7'h01 ==
    {1'b0, mem_data[5:0]} + tppt_pkg::WIDTH_EXTRA)
    else $error("step left before width plus two ticks");
  start_addr_a: assert property (
    dly_done && !start |=> st == CH_RUN && rd_addr == $past(begin_addr))
    else $error("pattern did not begin at start address");
  ascend_a: assert property (
    step && !at_end && !start |=> rd_addr == $past(rd_addr) + 7'h01)
    else $error("pattern address did not ascend");
  chan_delay_a: assert property (
    st == CH_DELAY && !start && dcnt != delay |=> st != CH_RUN)
    else $error("channel delay ended early");
  repeat_set_a: assert property (
    dly_done && !start && mul_sel == 1'b0 && loop_count != 8'h00
    |=> reps_left == {$past(loop_count), 4'h0})
    else $error("repeat count not scaled by sixteen");
  forever_run_a: assert property (
    st == CH_RUN && loop_count == 8'hFF && $stable(loop_count)
    && !start |=> st == CH_RUN)
    else $error("continuous pattern stopped");
endmodule

/* File: hdl/tppt_core.sv */
`timescale 1ns/1ps
// Overview of operation
// - each step lasts (field plus two) times N half periods
// - memory holds 128 bytes, state and length
// - entry top bits give channel output state
// - divide select 00=1, 01=2, else 4
// - common delay (16NB + 18N + 2) clock periods
// - channel delay adds N half periods times setting
// - external clock pair is the timing unit
// - begin and end addresses set pattern span
// - zero runs once, all ones runs forever
// - repeat multiplier select scales by 1 or 16
// - only masked-in channels drive pulses
module tppt_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clk_p,
  input wire logic ext_clk_n,
  input wire logic trig,
  output logic [31:0] tx_state,
  output logic [15:0] tx_busy
);
  logic [31:0] cfg;
  logic [31:0] loop_reg;
  logic [15:0] tx_channel_active_mask;
  logic [7:0] wave_mem [128];
  logic [8:0] chdl [16];
  logic [6:0] rd_addr [16];
  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
    {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire wr_cfg = wr_go && aw_addr == tppt_pkg::ADDR_CFG;
  wire wr_loop = wr_go && aw_addr == tppt_pkg::ADDR_LOOP;
  wire wr_mask = wr_go && aw_addr == tppt_pkg::ADDR_MASK;
  wire wr_chpage = aw_addr[11:6] == tppt_pkg::CHDL_PAGE;
  wire wr_mem = wr_go && aw_addr[11:9] == tppt_pkg::MEM_PAGE
    && w_strb[0];
  wire wr_ok = aw_addr == tppt_pkg::ADDR_CFG
    || aw_addr == tppt_pkg::ADDR_LOOP || aw_addr == tppt_pkg::ADDR_MASK
    || aw_addr == tppt_pkg::ADDR_STAT || wr_chpage
    || aw_addr[11:9] == tppt_pkg::MEM_PAGE;
  wire [6:0] wr_idx = aw_addr[8:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tppt_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'h0};
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? tppt_pkg::RESP_OKAY : tppt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= tppt_pkg::CFG_RST;
      loop_reg <= tppt_pkg::LOOP_RST;
      tx_channel_active_mask <= tppt_pkg::MASK_RST;
    end else begin
      if (wr_cfg) begin
        cfg <= (cfg & ~wmask) | (w_data & wmask);
      end
      if (wr_loop) begin
        loop_reg <= (loop_reg & ~wmask) | (w_data & wmask);
      end
      if (wr_mask) begin
        tx_channel_active_mask <= (tx_channel_active_mask & ~wmask[15:0])
          | (w_data[15:0] & wmask[15:0]);
      end
    end
  end

  // waveform memory, one byte per entry
  always_ff @(posedge aclk) begin
    if (wr_mem) begin
      wave_mem[wr_idx] <= w_data[7:0];
    end
  end

  wire [6:0] begin_addr = cfg[tppt_pkg::CFG_BEGIN_LSB +: 7];
  wire [6:0] end_addr = cfg[tppt_pkg::CFG_END_LSB +: 7];
  wire [1:0] clock_divide_select = cfg[tppt_pkg::CFG_DIV_LSB +: 2];
  wire repeat_multiplier_select = cfg[tppt_pkg::CFG_MUL_BIT];
  wire [7:0] burst_loop_count = loop_reg[tppt_pkg::LOOP_CNT_LSB +: 8];
  wire [7:0] common_delay_setting = loop_reg[tppt_pkg::LOOP_CDL_LSB +: 8];

  // read channel
  logic ext_p1, ext_p2, ext_n1, ext_n2, ext_lvl, trig1, trig2, trig3;
  logic cd_run;
  wire [15:0] ch_hit;
  wire [8:0] rd_chdl = chdl[s_axi_araddr[5:2]];
  wire rd_chpage = s_axi_araddr[11:6] == tppt_pkg::CHDL_PAGE;
  wire rd_mempage = s_axi_araddr[11:9] == tppt_pkg::MEM_PAGE;
  wire [11:0] rd_a = {s_axi_araddr[11:2], 2'h0};
  wire rd_ok = rd_a == tppt_pkg::ADDR_CFG || rd_a == tppt_pkg::ADDR_LOOP
    || rd_a == tppt_pkg::ADDR_MASK || rd_a == tppt_pkg::ADDR_STAT
    || rd_chpage || rd_mempage;
  wire [31:0] rd_val =
    rd_a == tppt_pkg::ADDR_CFG ? cfg :
    rd_a == tppt_pkg::ADDR_LOOP ? loop_reg :
    rd_a == tppt_pkg::ADDR_MASK ? {16'h0000, tx_channel_active_mask} :
    rd_a == tppt_pkg::ADDR_STAT ? {15'h0000, cd_run, tx_busy} :
    rd_chpage ? {23'h000000, rd_chdl} :
    rd_mempage ? {24'h000000, wave_mem[s_axi_araddr[8:2]]} :
    32'h0000_0000;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tppt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? tppt_pkg::RESP_OKAY : tppt_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // external clock pair and trigger, two-flop synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ext_p1, ext_p2, ext_n1, ext_n2, ext_lvl} <= 5'h00;
      {trig1, trig2, trig3} <= 3'h0;
    end else begin
      ext_p1 <= ext_clk_p;
      ext_p2 <= ext_p1;
      ext_n1 <= ext_clk_n;
      ext_n2 <= ext_n1;
      ext_lvl <= ext_p2 & ~ext_n2;
      trig1 <= trig;
      trig2 <= trig1;
      trig3 <= trig2;
    end
  end
  wire ext_now = ext_p2 & ~ext_n2;
  wire half_tick = ext_now ^ ext_lvl;
  wire ext_rise = ext_now & ~ext_lvl;
  wire trig_rise = trig2 & ~trig3;

  // divided half-period tick
  wire [1:0] div_last = clock_divide_select == 2'h0 ? 2'h0 :
    clock_divide_select == 2'h1 ? 2'h1 : 2'h3;
  logic [1:0] hcnt;
  logic go;
  wire div_tick = half_tick && hcnt >= div_last;

  // common delay in external periods
  wire [1:0] div_shift = clock_divide_select == 2'h0 ? 2'h0 :
    clock_divide_select == 2'h1 ? 2'h1 : 2'h2;
  wire [14:0] cd_base = {7'h00, common_delay_setting} * tppt_pkg::CDL_MUL
    + tppt_pkg::CDL_OFFS;
  wire [14:0] cd_target = (cd_base << div_shift)
    + tppt_pkg::CDL_TAIL;
  logic [14:0] cd_cnt;
  wire cd_done = cd_run && ext_rise
    && cd_cnt == cd_target - 15'h0001;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cd_run <= 1'b0;
      cd_cnt <= 15'h0000;
      go <= 1'b0;
      hcnt <= 2'h0;
    end else begin
      go <= cd_done;
      if (trig_rise && !cd_run) begin
        cd_run <= 1'b1;
        cd_cnt <= 15'h0000;
      end else if (cd_done) begin
        cd_run <= 1'b0;
      end else if (cd_run && ext_rise) begin
        cd_cnt <= cd_cnt + 15'h0001;
      end
      if (cd_done) begin
        hcnt <= 2'h0;
      end else if (half_tick) begin
        hcnt <= div_tick ? 2'h0 : hcnt + 2'h1;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_ch
      assign ch_hit[i] = wr_go && wr_chpage && aw_addr[5:2] == 4'(i);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          chdl[i] <= 9'h000;
        end else if (ch_hit[i] && w_strb[0]) begin
          chdl[i] <= {w_strb[1] ? w_data[8] : chdl[i][8], w_data[7:0]};
        end
      end
      tppt_chan u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(go),
        .tick(div_tick),
        .delay(chdl[i]),
        .begin_addr(begin_addr),
        .end_addr(end_addr),
        .loop_count(burst_loop_count),
        .mul_sel(repeat_multiplier_select),
        .enable(tx_channel_active_mask[i]),
        .mem_data(wave_mem[rd_addr[i]]),
        .rd_addr(rd_addr[i]),
        .state(tx_state[2 * i +: 2]),
        .busy(tx_busy[i])
      );
    end
  endgenerate

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mem_write_a: assert property (
    wr_mem |=> wave_mem[$past(wr_idx)] == $past(w_data[7:0]))
    else $error("waveform byte not stored");
  div_one_a: assert property (
    clock_divide_select == 2'h0 |-> div_tick == half_tick)
    else $error("divide by one dropped a half period");
  div_four_a: assert property (
    clock_divide_select[1] && div_tick |-> hcnt == 2'h3)
    else $error("divide by four ticked early");
  base_delay_a: assert property (
    cd_run && !cd_done && common_delay_setting == 8'h00
    && clock_divide_select == 2'h0 |-> cd_cnt <= 15'h0013)
    else $error("common delay overran its count");
  go_after_a: assert property (cd_done |=> go && !cd_run)
    else $error("channels not started after common delay");
  write_resp_a: assert property (wr_go |=> s_axi_bvalid)
    else $error("write response missing");
endmodule

/* File: hdl/tppt_pkg.sv */
package tppt_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_LOOP = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00C;
  // channel delays: base + 4 * channel, 16 words
  localparam logic [5:0] CHDL_PAGE = 6'h01;
  // waveform memory: base + 4 * entry, 128 words
  localparam logic [2:0] MEM_PAGE = 3'h1;
  // cfg fields
  localparam int CFG_BEGIN_LSB = 0;
  localparam int CFG_END_LSB = 8;
  localparam int CFG_DIV_LSB = 16;
  localparam int CFG_MUL_BIT = 18;
  // loop register fields
  localparam int LOOP_CNT_LSB = 0;
  localparam int LOOP_CDL_LSB = 8;
  // memory entry fields
  localparam int ENT_STATE_LSB = 6;
  localparam int ENT_WIDTH_MSB = 5;
  // reset values
  localparam logic [31:0] CFG_RST = 32'h0004_0000;
  localparam logic [31:0] LOOP_RST = 32'h0000_0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  // timing: common delay = (16*B + 18) * N + 2 periods
  localparam logic [14:0] CDL_MUL = 15'h0010;
  localparam logic [14:0] CDL_OFFS = 15'h0012;
  localparam logic [14:0] CDL_TAIL = 15'h0002;
  // width held for (field + 2) * N half periods
  localparam logic [6:0] WIDTH_EXTRA = 7'h02;
  localparam logic [7:0] LOOP_ONCE = 8'h00;
  localparam logic [7:0] LOOP_FOREVER = 8'hFF;
  localparam logic [11:0] REP_SCALE16 = 12'h010;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] STATE_IDLE = 2'h0;
endpackage

/* File: sim/tppt_ctrl_model.sv */
`timescale 1ns/1ps
module tppt_ctrl_model #(
  parameter realtime HALF = 413.0
) (
  input wire logic aclk,
  output logic ext_clk_p,
  output logic ext_clk_n,
  output logic trig
);
  // free running complementary reference pair
  initial begin
    ext_clk_p = 1'b0;
    ext_clk_n = 1'b1;
    trig = 1'b0;
    #7.3;
    forever begin
      #(HALF);
      ext_clk_p <= ~ext_clk_p;
      ext_clk_n <= ext_clk_p;
    end
  end
  // trigger raised just after a reference rising edge
  task automatic pulse_trig();
    @(posedge ext_clk_p);
    @(posedge aclk);
    trig <= 1'b1;
    repeat (8) @(posedge aclk);
    trig <= 1'b0;
  endtask
endmodule

/* File: sim/tx_pulse_pattern_timing_tb.sv */
`timescale 1ns/1ps
module tx_pulse_pattern_timing_tb;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, tx_state;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] tx_busy;
  logic ext_clk_p, ext_clk_n, trig;
  int error_cnt, n_compared, ecnt, e_trig, e_busy, e_ch1;
  int q0[$];
  logic [1:0] v0[$];
  logic busy_q, mask_bad;
  logic [1:0] st0_q, st1_q;

  tppt_core DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clk_p, .ext_clk_n,
    .trig, .tx_state, .tx_busy);
  tppt_ctrl_model u_ctrl (.aclk, .ext_clk_p, .ext_clk_n, .trig);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // reference edge counter and output monitor
  always @(ext_clk_p) ecnt++;
  always @(posedge trig) e_trig = ecnt;
  always @(posedge aclk) begin
    if (tx_busy[0] === 1'b1 && busy_q !== 1'b1 && e_busy < 0) e_busy = ecnt;
    if (tx_state[1:0] !== st0_q) begin
      q0.push_back(ecnt);
      v0.push_back(tx_state[1:0]);
    end
    if (tx_state[3:2] !== 2'h0 && st1_q === 2'h0 && e_ch1 < 0) e_ch1 = ecnt;
    if (tx_state[31:4] !== 28'h0) mask_bad = 1'b1;
    busy_q = tx_busy[0];
    st0_q = tx_state[1:0];
    st1_q = tx_state[3:2];
  end

  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1;
        s_axi_bready <= 1'b0;
        check("bresp", er, s_axi_bresp);
      end
    end
    check("bvalid", 1, done);
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] ed, logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1;
        s_axi_rready <= 1'b0;
        check("rdata", ed, s_axi_rdata);
        check("rresp", er, s_axi_rresp);
      end
    end
    check("rvalid", 1, done);
  endtask

  // one burst over entries 127 then 0, measured in reference edges
  task automatic run(logic [1:0] dv, logic [7:0] b, logic [7:0] cnt,
                     logic mul, int reps);
    int n, common_delay_time, w;
    n = (dv == 2'h0) ? 1 : (dv == 2'h1) ? 2 : 4;
    common_delay_time = 16 * n * b + 18 * n + 2;
    wr(12'h000, {13'h0, mul, dv, 8'h00, 8'h7F}, 2'h0);
    wr(12'h004, {16'h0, b, cnt}, 2'h0);
    q0.delete();
    v0.delete();
    e_busy = -1;
    e_ch1 = -1;
    mask_bad = 1'b0;
    u_ctrl.pulse_trig();
    for (int i = 0; i < 8000; i++) begin
      if (e_busy >= 0 && tx_busy[1:0] === 2'h0) break;
      @(posedge aclk);
    end
    check("tx_busy", 2'h0, tx_busy[1:0]);
    check("common delay", 2 * common_delay_time, e_busy - e_trig);
    check("steps", 2 * reps + 1, q0.size());
    for (int i = 0; i < 2 * reps && i + 1 < q0.size(); i++) begin
      w = (i % 2 == 0) ? 2 : 3;
      check("state", (i % 2 == 0) ? 2'h1 : 2'h2, v0[i]);
      check("width", n * w, q0[i + 1] - q0[i]);
    end
    check("chan delay", 3 * n, e_ch1 - q0[0]);
    check("masked", 1'b0, mask_bad);
  endtask

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h000, 32'h0004_0000, 2'h0);
    rd(12'h004, 32'h0, 2'h0);
    rd(12'h008, 32'h0, 2'h0);
    rd(12'h00C, 32'h0, 2'h0);
    wr(12'h100, 32'h1, 2'h2);
    rd(12'h100, 32'h0, 2'h2);
    wr(12'h07C, 32'h1FF, 2'h0);
    rd(12'h07C, 32'h1FF, 2'h0);
    wr(12'h07C, 32'h0, 2'h0);
    wr(12'h3FC, 32'h40, 2'h0);
    rd(12'h3FC, 32'h40, 2'h0);
    wr(12'h200, 32'h81, 2'h0);
    wr(12'h008, 32'h3, 2'h0);
    wr(12'h040, 32'h0, 2'h0);
    wr(12'h044, 32'h3, 2'h0);
    run(2'h0, 8'h00, 8'h00, 1'b1, 1);
    run(2'h1, 8'h01, 8'h02, 1'b1, 2);
    run(2'h2, 8'h00, 8'h00, 1'b1, 1);
    run(2'h3, 8'h00, 8'h01, 1'b0, 16);
    // continuous burst, then a reset in mid-run stops it
    wr(12'h004, 32'h0000_00FF, 2'h0);
    u_ctrl.pulse_trig();
    repeat (3000) @(posedge aclk);
    check("forever busy", 2'h3, tx_busy[1:0]);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h00C, 32'h0, 2'h0);
    check("reset state", 32'h0, tx_state);
    rd(12'h000, 32'h0004_0000, 2'h0);
    stop_test();
  end

  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    stop_test();
  end
endmodule
